// ---- src/fpcm_top.sv ----
// Floating-point enable gate, context stacking policy and mode registers behind APB.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps

// Operation
// [RQ1] Unit comes up disabled after reset.
// [RQ2] Disabled issue raises coprocessor-absent fault, no execute.
// [RQ3] No stacking: integer-only frame.
// [RQ4] Full stacking: push and restore FP context.
// [RQ5] Policy resets to lazy.
// [RQ6] Lazy entry reserves space, writes nothing.
// [RQ7] Lazy: first FP instruction saves context first.
// [RQ8] Lazy return restores only if written.
// [RQ9] Context is s0 through s15.
// [RQ10] Six separately enabled exception interrupt sources.
// [RQ11] Flush-to-zero setting, default off.
// [RQ12] Half format: IEEE or extended range.
// [RQ13] Half format resets to IEEE.
// [RQ14] NaN setting: pass through default, or canonical.
// [RQ15] Software sets modes before first FP instruction.
// [RQ16] Four rounding modes, nearest by default.
// [RQ17] Sticky flags; interrupt when enabled flag set.
// [RQ18] Two-bit policy sampled at exception entry.
module fpcm_top
  import fpcm_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // APB slave.
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic      [31:0] prdata_out,
  output logic             pslverr_out,
  // Core side.
  input  wire logic        fp_issue_in,         // Floating-point instruction issue pulse.
  input  wire logic        exc_entry_in,        // Exception entry pulse.
  input  wire logic        exc_return_in,       // Exception return pulse.
  input  wire logic        lazy_save_done_in,   // Stacker finished the lazy context write.
  input  wire logic [5:0]  exc_event_in,        // Datapath exception events.
  output logic             fp_exec_out,         // Instruction may execute, pulse.
  output logic             coprocessor_absent_fault_out,  // Usage fault, pulse.
  output logic             entry_push_fp_out,   // Write context at entry, pulse.
  output logic             entry_reserve_fp_out, // Reserve context space at entry, pulse.
  output logic      [4:0]  frame_words_out,     // Words of the last entry frame.
  output logic             lazy_save_req_out,   // Write pending context, level.
  output logic             restore_fp_out,      // Pop context on return, pulse.
  output logic             fpu_enabled_out,
  output logic             denormal_flush_on_out,
  output logic             half_format_extended_range_out,
  output logic             nan_canonical_result_out,
  output logic      [1:0]  round_mode_out,
  output logic             fp_irq_out
);

  // ---------------------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------------------
  // Sequencer states: normal running, or waiting for a lazy context write.
  typedef enum logic { ST_RUN, ST_SAVE } fpcm_state_e;

  typedef struct packed {
    logic        pready;     // APB ready, one wait state per access.
    logic [31:0] prdata;     // APB read data.
    logic        pslverr;    // APB error for unmapped offsets.
    logic        fpu_en;     // Unit enable.
    logic [1:0]  policy;     // Context policy setting.
    logic        flush;      // Flush-to-zero.
    logic        half_alt;   // Extended-range half format.
    logic        nan_def;    // Canonical NaN results.
    logic [1:0]  rmode;      // Rounding mode.
    logic [5:0]  irq_en;     // Flag interrupt enables.
    fpcm_state_e st;         // Sequencer state.
    logic        frm_full;   // Current frame holds a full context.
    logic        frm_pend;   // Current frame has reserved, unwritten space.
    logic        frm_writ;   // Context was written in the current frame.
    logic        fp_exec;    // Execute pulse.
    logic        fault;      // Fault pulse.
    logic        push;       // Entry push pulse.
    logic        reserve;    // Entry reserve pulse.
    logic [4:0]  words;      // Frame size of last entry.
    logic        lazy_req;   // Lazy save request level.
    logic        restore;    // Return restore pulse.
  } fpcm_s;

  fpcm_s state_reg;
  fpcm_s state_next;

  // ---------------------------------------------------------------------------
  // Bus decode helpers
  // ---------------------------------------------------------------------------
  logic       acc_phase;    // Access phase before ready is raised.
  logic       wr_commit;    // Write takes effect at this edge.
  logic [5:0] flag_clear;   // Write-one-to-clear strobes.
  logic [5:0] flags;        // Sticky flags from the flag block.
  logic       irq;          // Interrupt level from the flag block.

  // Tells whether an offset belongs to a register.
  function automatic logic fpcm_mapped(input logic [7:0] a);
    fpcm_mapped = (a == FPCM_CTRL_OFF) || (a == FPCM_MODE_OFF) ||
                  (a == FPCM_FLAGS_OFF) || (a == FPCM_IRQEN_OFF) ||
                  (a == FPCM_STATUS_OFF);
  endfunction

  // The ready flop is raised one cycle into the access phase; the write then commits
  // on the edge where the master samples ready high.
  assign acc_phase  = psel_in && penable_in && !state_reg.pready;
  assign wr_commit  = psel_in && penable_in && state_reg.pready && pwrite_in;
  assign flag_clear = (wr_commit && paddr_in == FPCM_FLAGS_OFF) ?
                      pwdata_in[5:0] : 6'h00;

  // ---------------------------------------------------------------------------
  // Exception flags and interrupt
  // ---------------------------------------------------------------------------
  fpcm_exc_flags #(
    .N          (NUM_FLAGS)
  ) u_flags (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .set_in     (exc_event_in),
    .clear_in   (flag_clear),
    .enable_in  (state_reg.irq_en),
    .flags_out  (flags),
    .irq_out    (irq)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // One process holds the bus slave, the register writes and the context sequencer.
  always_comb begin
    state_next         = state_reg;
    state_next.fp_exec = 1'b0;
    state_next.fault   = 1'b0;
    state_next.push    = 1'b0;
    state_next.reserve = 1'b0;
    state_next.restore = 1'b0;
    state_next.pready  = acc_phase;
    state_next.pslverr = acc_phase && !fpcm_mapped(paddr_in);

    // Read data is captured with ready; other cycles return zero.
    state_next.prdata = 32'h0000_0000;
    if (acc_phase && !pwrite_in) begin
      unique case (paddr_in)
        FPCM_CTRL_OFF: begin
          state_next.prdata[CTRL_EN_BIT] = state_reg.fpu_en;
          state_next.prdata[CTRL_POL_LSB +: 2] = state_reg.policy;
        end
        FPCM_MODE_OFF: begin
          state_next.prdata[MODE_FLUSH_BIT] = state_reg.flush;
          state_next.prdata[MODE_HALF_BIT] = state_reg.half_alt;
          state_next.prdata[MODE_NAN_BIT] = state_reg.nan_def;
          state_next.prdata[MODE_RND_LSB +: 2] = state_reg.rmode;
        end
        FPCM_FLAGS_OFF: begin
          state_next.prdata[5:0] = flags;
        end
        FPCM_IRQEN_OFF: begin
          state_next.prdata[5:0] = state_reg.irq_en;
        end
        FPCM_STATUS_OFF: begin
          state_next.prdata[STAT_PEND_BIT] = state_reg.frm_pend;
          state_next.prdata[STAT_WRIT_BIT] = state_reg.frm_writ;
          state_next.prdata[STAT_FULL_BIT] = state_reg.frm_full;
          state_next.prdata[STAT_SAVE_BIT] = (state_reg.st == ST_SAVE);
        end
        default: begin
          state_next.prdata = 32'h0000_0000;
        end
      endcase
    end

    // Register writes.
    if (wr_commit) begin
      unique case (paddr_in)
        FPCM_CTRL_OFF: begin
          state_next.fpu_en = pwdata_in[CTRL_EN_BIT];
          // The unused fourth code is ignored so the policy stays one of three.
          if (pwdata_in[CTRL_POL_LSB +: 2] != 2'h3) begin
            state_next.policy = pwdata_in[CTRL_POL_LSB +: 2];  // [RQ18]
          end
        end
        FPCM_MODE_OFF: begin
          state_next.flush    = pwdata_in[MODE_FLUSH_BIT];     // [RQ11]
          state_next.half_alt = pwdata_in[MODE_HALF_BIT];      // [RQ12]
          state_next.nan_def  = pwdata_in[MODE_NAN_BIT];       // [RQ14]
          state_next.rmode    = pwdata_in[MODE_RND_LSB +: 2];  // [RQ16]
        end
        FPCM_IRQEN_OFF: begin
          state_next.irq_en = pwdata_in[5:0];  // [RQ10]
        end
        default: begin
          state_next.irq_en = state_reg.irq_en;
        end
      endcase
    end

    // Context sequencer. Only one frame level is tracked; a nested entry in ST_RUN
    // restarts the frame bookkeeping, while one in ST_SAVE is ignored.
    unique case (state_reg.st)
      ST_RUN: begin
        if (exc_entry_in) begin
          // The policy is sampled here, so a later change affects the next frame.
          unique case (state_reg.policy)  // [RQ18]
            POL_FULL: begin
              state_next.push     = 1'b1;            // [RQ4] [RQ9]
              state_next.words    = FRAME_FP_WORDS;
              state_next.frm_full = 1'b1;
              state_next.frm_pend = 1'b0;
            end
            POL_LAZY: begin
              state_next.reserve  = 1'b1;            // [RQ6] [RQ9]
              state_next.words    = FRAME_FP_WORDS;
              state_next.frm_full = 1'b0;
              state_next.frm_pend = 1'b1;
            end
            default: begin
              state_next.words    = FRAME_INT_WORDS;  // [RQ3]
              state_next.frm_full = 1'b0;
              state_next.frm_pend = 1'b0;
            end
          endcase
          state_next.frm_writ = 1'b0;
        end else if (exc_return_in) begin
          // Restore only what was really written into the frame.
          state_next.restore  = state_reg.frm_full || state_reg.frm_writ;  // [RQ4] [RQ8]
          state_next.frm_full = 1'b0;
          state_next.frm_pend = 1'b0;
          state_next.frm_writ = 1'b0;
        end else if (fp_issue_in) begin
          if (!state_reg.fpu_en) begin
            state_next.fault = 1'b1;  // [RQ1] [RQ2]
          end else if (state_reg.frm_pend) begin
            // Hold the instruction back until the reserved space is filled.
            state_next.st       = ST_SAVE;  // [RQ7]
            state_next.lazy_req = 1'b1;     // [RQ7]
          end else begin
            state_next.fp_exec = 1'b1;
          end
        end
      end
      ST_SAVE: begin
        if (lazy_save_done_in) begin
          state_next.st       = ST_RUN;
          state_next.lazy_req = 1'b0;
          state_next.frm_pend = 1'b0;
          state_next.frm_writ = 1'b1;  // [RQ8]
          state_next.fp_exec  = 1'b1;  // [RQ7]
        end
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // All control state takes a constant at reset; modes come up at their defaults.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg          <= '0;
      state_reg.fpu_en   <= RST_FPU_EN;    // [RQ1]
      state_reg.policy   <= RST_POLICY;    // [RQ5]
      state_reg.flush    <= RST_FLUSH;     // [RQ11]
      state_reg.half_alt <= RST_HALF;      // [RQ13]
      state_reg.nan_def  <= RST_NAN;       // [RQ14]
      state_reg.rmode    <= RST_ROUND;     // [RQ16]
      state_reg.st       <= ST_RUN;
      state_reg.words    <= FRAME_INT_WORDS;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, all straight from flops
  // ---------------------------------------------------------------------------
  assign pready_out                     = state_reg.pready;
  assign prdata_out                     = state_reg.prdata;
  assign pslverr_out                    = state_reg.pslverr;
  assign fp_exec_out                    = state_reg.fp_exec;
  assign coprocessor_absent_fault_out   = state_reg.fault;
  assign entry_push_fp_out              = state_reg.push;
  assign entry_reserve_fp_out           = state_reg.reserve;
  assign frame_words_out                = state_reg.words;
  assign lazy_save_req_out              = state_reg.lazy_req;
  assign restore_fp_out                 = state_reg.restore;
  assign fpu_enabled_out                = state_reg.fpu_en;
  assign denormal_flush_on_out          = state_reg.flush;
  assign half_format_extended_range_out = state_reg.half_alt;
  assign nan_canonical_result_out       = state_reg.nan_def;
  assign round_mode_out                 = state_reg.rmode;
  assign fp_irq_out                     = irq;

endmodule

// ---- src/fpcm_pkg.sv ----
// Package with constants for the floating-point context and mode control.
package fpcm_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets on the APB port
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FPCM_CTRL_OFF   = 8'h00;  // Enable and context policy.
  localparam logic [7:0] FPCM_MODE_OFF   = 8'h04;  // Arithmetic mode settings.
  localparam logic [7:0] FPCM_FLAGS_OFF  = 8'h08;  // Sticky exception flags, write 1 clears.
  localparam logic [7:0] FPCM_IRQEN_OFF  = 8'h0C;  // Per-flag interrupt enables.
  localparam logic [7:0] FPCM_STATUS_OFF = 8'h10;  // Read-only context state.

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_EN_BIT     = 0;  // Unit enable.
  localparam int CTRL_POL_LSB    = 1;  // Two-bit context policy, bits 2:1.
  localparam int MODE_FLUSH_BIT  = 0;  // Flush-to-zero.
  localparam int MODE_HALF_BIT   = 1;  // Half-precision extended-range format.
  localparam int MODE_NAN_BIT    = 2;  // Canonical NaN results.
  localparam int MODE_RND_LSB    = 3;  // Two-bit rounding mode, bits 4:3.
  localparam int STAT_PEND_BIT   = 0;  // Lazy save still pending.
  localparam int STAT_WRIT_BIT   = 1;  // Context written in current frame.
  localparam int STAT_FULL_BIT   = 2;  // Current frame uses full stacking.
  localparam int STAT_SAVE_BIT   = 3;  // Lazy save in progress.

  // ---------------------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------------------
  localparam logic [1:0] POL_NONE = 2'h0;  // No floating-point stacking.
  localparam logic [1:0] POL_FULL = 2'h1;  // Always stack the context.
  localparam logic [1:0] POL_LAZY = 2'h2;  // Reserve at entry, write on first use.

  localparam logic [1:0] RND_NEAREST            = 2'h0;
  localparam logic [1:0] RND_ROUND_UP_POSITIVE  = 2'h1;
  localparam logic [1:0] RND_ROUND_DOWN_NEGATIVE = 2'h2;
  localparam logic [1:0] RND_ZERO               = 2'h3;

  localparam logic       RST_FPU_EN   = 1'b0;      // Unit disabled out of reset.
  localparam logic [1:0] RST_POLICY   = POL_LAZY;  // Lazy policy out of reset.
  localparam logic       RST_FLUSH    = 1'b0;      // Full IEEE handling.
  localparam logic       RST_HALF     = 1'b0;      // IEEE half format.
  localparam logic       RST_NAN      = 1'b0;      // NaNs pass through.
  localparam logic [1:0] RST_ROUND    = RND_NEAREST;

  // Exception flag bit order.
  localparam int FLAG_UNDERFLOW = 0;
  localparam int FLAG_OVERFLOW  = 1;
  localparam int FLAG_DIVZERO   = 2;
  localparam int FLAG_INVALID   = 3;
  localparam int FLAG_DENORMAL  = 4;
  localparam int FLAG_INEXACT   = 5;
  localparam int NUM_FLAGS      = 6;

  // Stack frame sizes in words.
  localparam int          FP_CTX_REGS     = 16;  // Registers s0 through s15.
  localparam logic [4:0]  FRAME_INT_WORDS = 5'h08;
  localparam logic [4:0]  FRAME_FP_WORDS  = 5'h1A;

endpackage

// ---- src/fpcm_exc_flags.sv ----
// Sticky floating-point exception flags with enable gating onto one interrupt line.
`timescale 1ns/1ps
module fpcm_exc_flags
  import fpcm_pkg::*;
#(
  parameter int N = NUM_FLAGS
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [N-1:0] set_in,
  input  wire logic [N-1:0] clear_in,
  input  wire logic [N-1:0] enable_in,
  output logic      [N-1:0] flags_out,
  output logic              irq_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0] flags;  // Sticky flags.
    logic         irq;    // Registered interrupt level.
  } fpcm_flag_s;

  fpcm_flag_s state_reg;
  fpcm_flag_s state_next;

  // A new event in the same cycle as a clear keeps the flag set, so nothing is lost.
  always_comb begin
    state_next       = state_reg;
    state_next.flags = (state_reg.flags & ~clear_in) | set_in;  // [RQ17]
    state_next.irq   = |(state_next.flags & enable_in);         // [RQ17] [RQ10]
  end

  // Register the whole state.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags_out = state_reg.flags;
  assign irq_out   = state_reg.irq;

endmodule

// ---- verification/fpcm_core_model.sv ----
// Behavioural model of the core's stacking engine that answers lazy context writes.
`timescale 1ns/1ps
module fpcm_core_model
  import fpcm_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       lazy_save_req_in,  // Pending context write request.
  input  wire logic [3:0] save_delay_in,     // Extra cycles before the write completes.
  output logic            lazy_save_done_out // One-cycle completion pulse.
);
  logic [3:0] wait_reg;  // Cycles spent on the current context write.

  // A delay of 15 stands for one cycle per register of s0 to s15; 0 is a prompt stacker.
  // The pulse lasts one cycle so a second request is never answered by a stale pulse.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lazy_save_done_out <= 1'b0;
      wait_reg           <= 4'h0;
    end else if (lazy_save_done_out) begin
      lazy_save_done_out <= 1'b0;
      wait_reg           <= 4'h0;
    end else if (lazy_save_req_in) begin
      if (wait_reg == save_delay_in) begin
        lazy_save_done_out <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

// ---- verification/fpcm_monitor.sv ----
// Concurrent checks on the ports of the floating-point context and mode control.
`timescale 1ns/1ps
module fpcm_monitor
  import fpcm_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       reset_n_in,
  input wire logic       fp_issue_in,
  input wire logic       exc_entry_in,
  input wire logic       exc_return_in,
  input wire logic       lazy_save_done_in,
  input wire logic       fp_exec_out,
  input wire logic       coprocessor_absent_fault_out,
  input wire logic       entry_push_fp_out,
  input wire logic       entry_reserve_fp_out,
  input wire logic [4:0] frame_words_out,
  input wire logic       lazy_save_req_out,
  input wire logic       restore_fp_out,
  input wire logic       fpu_enabled_out,
  input wire logic [1:0] round_mode_out
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_RST_DEFAULTS: assert property (!$past(reset_n_in) |-> !fpu_enabled_out
    && round_mode_out == 2'h0 && frame_words_out == 5'h08)
    else $error("outputs not at defaults after reset");
  AST_FAULT_ON_OFF: assert property (fp_issue_in && !fpu_enabled_out && !lazy_save_req_out
    && !exc_entry_in && !exc_return_in |=> coprocessor_absent_fault_out && !fp_exec_out)
    else $error("disabled issue did not fault");
  AST_FAULT_CAUSE: assert property (coprocessor_absent_fault_out |->
    $past(fp_issue_in) && !$past(fpu_enabled_out))
    else $error("fault without disabled issue");
  AST_ENTRY_FRAME: assert property (exc_entry_in && !lazy_save_req_out |=>
    (entry_push_fp_out || entry_reserve_fp_out) == (frame_words_out == 5'h1A))
    else $error("entry frame size disagrees with context handling");
  AST_PUSH_FRAME: assert property (entry_push_fp_out |->
    frame_words_out == 5'h1A && !entry_reserve_fp_out)
    else $error("full push without full frame");
  AST_RESERVE_FRAME: assert property (entry_reserve_fp_out |-> frame_words_out == 5'h1A)
    else $error("lazy reserve without context space");
  AST_LAZY_HOLD: assert property (lazy_save_req_out && !lazy_save_done_in |=>
    lazy_save_req_out && !fp_exec_out)
    else $error("lazy request dropped before completion");
  AST_LAZY_EXEC: assert property (lazy_save_req_out && lazy_save_done_in |=>
    !lazy_save_req_out && fp_exec_out)
    else $error("instruction not released after context write");
  AST_RESTORE_CAUSE: assert property (restore_fp_out |-> $past(exc_return_in))
    else $error("restore without exception return");
endmodule

bind fpcm_top fpcm_monitor u_mon (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .fp_issue_in(fp_issue_in),
  .exc_entry_in(exc_entry_in), .exc_return_in(exc_return_in),
  .lazy_save_done_in(lazy_save_done_in), .fp_exec_out(fp_exec_out),
  .coprocessor_absent_fault_out(coprocessor_absent_fault_out),
  .entry_push_fp_out(entry_push_fp_out), .entry_reserve_fp_out(entry_reserve_fp_out),
  .frame_words_out(frame_words_out), .lazy_save_req_out(lazy_save_req_out),
  .restore_fp_out(restore_fp_out), .fpu_enabled_out(fpu_enabled_out),
  .round_mode_out(round_mode_out)
);

// ---- verification/fpcm_top_test.sv ----
// Self-checking bench for the floating-point context and mode control.
`timescale 1ns/1ps
module fpcm_top_test;
  import fpcm_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, iss = 0, ent = 0, ret = 0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0000_0000, rd;
  logic [5:0]  ev = 6'h00, m_flags, m_ie, c;
  logic [3:0]  dly = 4'h0;
  logic [4:0]  mv;  // Mode value written in the mode scenario.
  logic        er, m_en = 0, pend = 0, writ = 0, full = 0;  // Behavioural model state.
  logic [1:0]  m_pol = 2'h2;
  logic [1:0]  pols [6] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 2'h1};
  wire         prdy, perr, exe, flt, push, rsv, lreq, rsto, en_o, fl_o, hf_o, nan_o, irq, done;
  wire  [31:0] prd;
  wire  [4:0]  wrd;
  wire  [1:0]  rnd_o;
  int          miscompares = 0, check_count = 0;

  fpcm_top u_dut (.sys_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .pready_out(prdy), .prdata_out(prd),
    .pslverr_out(perr), .fp_issue_in(iss), .exc_entry_in(ent), .exc_return_in(ret),
    .lazy_save_done_in(done), .exc_event_in(ev), .fp_exec_out(exe),
    .coprocessor_absent_fault_out(flt), .entry_push_fp_out(push), .entry_reserve_fp_out(rsv),
    .frame_words_out(wrd), .lazy_save_req_out(lreq), .restore_fp_out(rsto),
    .fpu_enabled_out(en_o), .denormal_flush_on_out(fl_o), .half_format_extended_range_out(hf_o),
    .nan_canonical_result_out(nan_o), .round_mode_out(rnd_o), .fp_irq_out(irq));
  fpcm_core_model u_core (.sys_clk_in(clk), .reset_n_in(rst_n), .lazy_save_req_in(lreq),
    .save_delay_in(dly), .lazy_save_done_out(done));

  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; the request is held until the edge that samples pready high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; padr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1;
    // Ready and read data are taken at the edge itself, before the design updates them.
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 0; pen <= 0;
    // Step off the edge so callers see settled outputs; the watchdog ends a hang.
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(er, 0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(er, 0);
    chk(rd, e);
  endtask

  // Entry (k=0) or return (k=1) pulse; answers are registered, so look one cycle later.
  task automatic core(input int k);
    @(posedge clk);
    if (k == 0) ent <= 1; else ret <= 1;
    @(posedge clk);
    ent <= 0; ret <= 0;
    #1;
  endtask

  task automatic issue();
    int n;
    n = 0;
    @(posedge clk);
    iss <= 1;
    @(posedge clk);
    iss <= 0;
    #1;
    if (!m_en) chk({flt, exe, lreq}, 3'b100);
    else if (!pend) chk({flt, exe, lreq}, 3'b010);
    else begin
      chk({flt, exe, lreq}, 3'b001);
      while (exe !== 1'b1 && n < 40) begin
        @(posedge clk);
        #1 n++;
      end
      chk({exe, lreq}, 2'b10);
      pend = 0;
      writ = 1;
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 5000 cycles.
  initial begin
    #(25 * 40000);
    miscompares++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hab592529));
    repeat (20) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    #1 chk(en_o, 0);
    chk({fl_o, hf_o, nan_o, rnd_o, wrd}, {5'h00, 5'h08});
    rdc(FPCM_CTRL_OFF, 32'h0000_0004);
    rdc(FPCM_MODE_OFF, 32'h0000_0000);
    rdc(FPCM_STATUS_OFF, 32'h0000_0000);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(er, 1);
    chk(rd, 32'h0000_0000);
    wr(FPCM_STATUS_OFF, 32'hFFFF_FFFF);
    rdc(FPCM_STATUS_OFF, 32'h0000_0000);
    issue();
    // Modes are set while the unit is still off, before any instruction runs.
    for (int i = 0; i < 4; i++) begin
      mv = {2'(i), 3'($urandom)};
      wr(FPCM_MODE_OFF, {27'h0, mv});
      chk({rnd_o, nan_o, hf_o, fl_o}, mv);
      rdc(FPCM_MODE_OFF, {27'h0, mv});
    end
    m_en = 1;
    // Every policy, lazy both with and without use in the handler, and the unused code.
    for (int i = 0; i < 6; i++) begin
      dly <= ($urandom & 1) ? 4'hF : 4'h0;
      wr(FPCM_CTRL_OFF, {29'h0, pols[i], 1'b1});
      if (pols[i] != 2'h3) m_pol = pols[i];
      rdc(FPCM_CTRL_OFF, {29'h0, m_pol, 1'b1});
      core(0);
      chk({push, rsv, wrd}, {m_pol == 2'h1, m_pol == 2'h2, (m_pol == 2'h0) ? 5'h08 : 5'h1A});
      full = (m_pol == 2'h1);
      pend = (m_pol == 2'h2);
      writ = 0;
      if (i != 3) issue();
      rdc(FPCM_STATUS_OFF, {29'h0, full, writ, pend});
      core(1);
      chk(rsto, full | writ);
    end
    wr(FPCM_CTRL_OFF, 32'h0000_0000);
    m_en = 0;
    issue();
    m_flags = 6'h00;
    // Sticky flags and their interrupt enables, all six sources set on the first pass.
    for (int i = 0; i < 4; i++) begin
      m_ie = 6'($urandom);
      wr(FPCM_IRQEN_OFF, {26'h0, m_ie});
      c = (i == 0) ? 6'h3F : 6'($urandom);
      @(posedge clk);
      ev <= c;
      @(posedge clk);
      ev <= 6'h00;
      m_flags = m_flags | c;
      rdc(FPCM_FLAGS_OFF, {26'h0, m_flags});
      chk(irq, |(m_flags & m_ie));
      c = 6'($urandom);
      wr(FPCM_FLAGS_OFF, {26'h0, c});
      m_flags = m_flags & ~c;
      rdc(FPCM_FLAGS_OFF, {26'h0, m_flags});
      chk(irq, |(m_flags & m_ie));
    end
    give_verdict();
  end
endmodule
